//--- src/pushbutton_message_manager.sv
// push-button control: pointers, cue slots, record flow and led indication
`timescale 1ns/1ps
module pushbutton_message_manager #(
    parameter int HOLD_CYCLES   = pbm_pkg::HOLD_CYCLES,
    parameter int BLINK_CYCLES  = pbm_pkg::DEFAULT_BLINK_CYCLES,
    parameter int DEBOUNCE_CYCLES = pbm_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // buttons and straps
    input  wire pbm_pkg::keys_s           keys,
    input  wire logic                     passthru_select_n,
    input  wire logic                     monitor_en,
    input  wire logic                     mix_en,
    input  wire logic [2:0]               rate_sel,
    // stored-state restore after reset, cue programming and array status
    input  wire logic                     restore_valid,
    input  wire logic                     restore_has_msgs,
    input  wire logic                     restore_corrupt,
    input  wire logic [pbm_pkg::ROW_W-1:0] restore_last_start,
    input  wire logic [pbm_pkg::ROW_W-1:0] restore_next_free,
    input  wire logic [3:0]               cue_programmed,
    input  wire logic                     array_full,
    input  wire logic                     array_row_done,
    input  wire logic                     cue_play_done,
    // array and analog path
    output pbm_pkg::array_cmd_s           array_cmd,
    output pbm_pkg::analog_path_s         analog_path,
    output logic                          powered_down,
    output logic                          cue_edit_mode,
    // indicator
    output logic                          led
);
    localparam int W = pbm_pkg::ROW_W;

    typedef enum logic [2:0] {
        ST_INIT   = 3'b000,
        ST_IDLE   = 3'b001,
        ST_CUE_IN = 3'b010,
        ST_REC    = 3'b011,
        ST_CUE_OUT = 3'b100,
        ST_IND    = 3'b101,
        ST_EDITOP = 3'b110
    } state_e;

    // wrap message row within circular area
    function automatic logic [W-1:0] next_row(input logic [W-1:0] r);
        next_row = (r == pbm_pkg::LAST_ROW) ? pbm_pkg::FIRST_MSG_ROW : W'(r + 1'b1);
    endfunction

    // row of cue slot
    function automatic logic [W-1:0] cue_row(input logic [1:0] c);
        cue_row = W'({c, 2'b00});
    endfunction

    // cue length in cycles for rate code
    function automatic logic [31:0] cue_cycles(input logic [2:0] s);
        unique case (s)
            3'd0:    cue_cycles = 32'(pbm_pkg::CUE_MS_12K * (pbm_pkg::CLK_HZ / 1000));
            3'd1:    cue_cycles = 32'(pbm_pkg::CUE_MS_8K * (pbm_pkg::CLK_HZ / 1000));
            3'd2:    cue_cycles = 32'(pbm_pkg::CUE_MS_6K4 * (pbm_pkg::CLK_HZ / 1000));
            3'd3:    cue_cycles = 32'(pbm_pkg::CUE_MS_5K3 * (pbm_pkg::CLK_HZ / 1000));
            default: cue_cycles = 32'(pbm_pkg::CUE_MS_4K * (pbm_pkg::CLK_HZ / 1000));
        endcase
    endfunction

    // debounce: stable level for DEBOUNCE_CYCLES
    logic [3:0]  raw, db_reg, db_next, db_prev_reg;
    logic [31:0] dbc_reg, dbc_next;
    assign raw = ~keys; // active high: capture, advance, listen, clear

    always_comb begin
        db_next  = db_reg;
        dbc_next = 32'h0;
        if (raw != db_reg) begin
            dbc_next = dbc_reg + 32'h1;
            if (dbc_reg >= 32'(DEBOUNCE_CYCLES)) begin
                db_next  = raw;
                dbc_next = 32'h0;
            end
        end
    end

    wire cap = db_reg[3];
    wire adv = db_reg[2];
    wire cap_rise = db_reg[3] & ~db_prev_reg[3];
    wire cap_fall = ~db_reg[3] & db_prev_reg[3];
    wire adv_rise = db_reg[2] & ~db_prev_reg[2];
    wire lis_rise = db_reg[1] & ~db_prev_reg[1];
    wire clr_rise = db_reg[0] & ~db_prev_reg[0];

    // blink sequencer
    logic        bl_start;
    logic [3:0]  bl_count;
    logic [31:0] bl_period;
    logic        bl_led, bl_busy;

    blink_unit #(.CNT_W(32)) u_blink (
        .clk    (clk),
        .sys_rst(sys_rst),
        .start  (bl_start),
        .count  (bl_count),
        .period (bl_period),
        .led    (bl_led),
        .busy   (bl_busy)
    );

    state_e       st_reg, st_next;
    logic [W-1:0] rec_ptr_reg, rec_ptr_next, play_ptr_reg, play_ptr_next, start_reg, start_next;
    logic         has_msgs_reg, has_msgs_next, corrupt_reg, corrupt_next;
    logic         edit_reg, edit_next, hold_done_reg, hold_done_next;
    logic [1:0]   cue_sel_reg, cue_sel_next;
    logic [31:0]  hold_reg, hold_next;
    logic         led_next;
    pbm_pkg::array_cmd_s cmd_next;
    pbm_pkg::analog_path_s path_next;

    // indication request: cue c, n blinks, period by programming
    task automatic indicate(input logic [1:0] c, input logic [3:0] n);
        bl_start  = 1'b1;
        bl_count  = n;
        bl_period = cue_programmed[c] ? cue_cycles(rate_sel) : 32'(BLINK_CYCLES);
        if (cue_programmed[c]) begin
            cmd_next.play = 1'b1;
            cmd_next.row  = cue_row(c);
        end
    endtask

    always_comb begin
        st_next       = st_reg;
        rec_ptr_next  = rec_ptr_reg;
        play_ptr_next = play_ptr_reg;
        start_next    = start_reg;
        has_msgs_next = has_msgs_reg;
        corrupt_next  = corrupt_reg;
        edit_next     = edit_reg;
        cue_sel_next  = cue_sel_reg;
        hold_done_next = hold_done_reg;
        hold_next     = adv ? ((hold_reg < 32'(HOLD_CYCLES)) ? hold_reg + 32'h1 : hold_reg) : 32'h0;
        led_next      = bl_led;
        bl_start      = 1'b0;
        bl_count      = 4'h0;
        bl_period     = 32'h0;
        cmd_next      = '0;
        cmd_next.row  = array_cmd.row;
        if (!adv) begin
            hold_done_next = 1'b0;
        end
        unique case (st_reg)
            ST_INIT: begin
                if (restore_valid) begin
                    has_msgs_next = restore_has_msgs;
                    corrupt_next  = restore_corrupt;
                    rec_ptr_next  = restore_has_msgs ? restore_next_free : pbm_pkg::FIRST_MSG_ROW;
                    play_ptr_next = restore_has_msgs ? restore_last_start : pbm_pkg::FIRST_MSG_ROW;
                    st_next       = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (bl_busy) begin
                    st_next = ST_IDLE;
                end else if (corrupt_reg && (cap_rise || adv_rise || lis_rise || clr_rise)) begin
                    bl_start  = 1'b1;
                    bl_count  = 4'(pbm_pkg::CORRUPT_BLINKS);
                    bl_period = 32'(BLINK_CYCLES);
                end else if (adv && cap && hold_reg >= 32'(HOLD_CYCLES) && !hold_done_reg) begin
                    hold_done_next = 1'b1;
                    edit_next      = ~edit_reg;
                    cue_sel_next   = 2'd0;
                    if (edit_reg) begin
                        indicate(2'd1, 4'h2);
                    end else begin
                        indicate(2'd0, 4'h2);
                    end
                end else if (cap_rise) begin
                    start_next = edit_reg ? cue_row(cue_sel_reg) : rec_ptr_reg;
                    if (!edit_reg && cue_programmed[0]) begin
                        indicate(2'd0, 4'h1);
                        st_next = ST_CUE_IN;
                    end else begin
                        led_next = 1'b1;
                        cmd_next.record = 1'b1;
                        cmd_next.row    = edit_reg ? cue_row(cue_sel_reg) : rec_ptr_reg;
                        st_next = ST_REC;
                    end
                end else if (edit_reg && adv_rise) begin
                    cue_sel_next = cue_sel_reg + 2'd1;
                    indicate(2'(cue_sel_reg + 2'd1), 4'({2'b00, 2'(cue_sel_reg + 2'd1)} + 4'h1));
                end else if (edit_reg && (lis_rise || clr_rise)) begin
                    cmd_next.play  = lis_rise;
                    cmd_next.erase = clr_rise;
                    cmd_next.row   = cue_row(cue_sel_reg);
                    st_next = ST_EDITOP;
                end else if (!edit_reg && adv && hold_reg == 32'(HOLD_CYCLES) - 32'h1) begin
                    if (!has_msgs_reg || next_row(play_ptr_reg) == rec_ptr_reg) begin
                        indicate(2'd1, 4'h2);
                    end else begin
                        indicate(2'd0, 4'h1);
                    end
                end
            end
            ST_CUE_IN: begin
                if (!bl_busy) begin
                    led_next = 1'b1;
                    cmd_next.record = 1'b1;
                    cmd_next.row    = start_reg;
                    st_next = ST_REC;
                end
            end
            ST_REC: begin
                led_next = 1'b1;
                cmd_next.record = 1'b1;
                if (array_row_done && !edit_reg) begin
                    cmd_next.row = next_row(array_cmd.row);
                end
                if (cap_fall || !cap || array_full) begin
                    cmd_next.record = 1'b0;
                    if (!edit_reg) begin
                        rec_ptr_next  = next_row(array_cmd.row);
                        play_ptr_next = start_reg;
                        has_msgs_next = 1'b1;
                    end
                    if (!edit_reg && cue_programmed[1]) begin
                        indicate(2'd1, 4'h2);
                    end else begin
                        led_next = 1'b0;
                    end
                    st_next = ST_CUE_OUT;
                end
            end
            ST_CUE_OUT: begin
                if (!bl_busy) begin
                    st_next = ST_IDLE;
                end
            end
            ST_EDITOP: begin
                cmd_next.play  = array_cmd.play;
                cmd_next.erase = array_cmd.erase;
                if (cue_play_done) begin
                    cmd_next = '0;
                    cmd_next.row = array_cmd.row;
                    st_next  = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        if (st_reg == ST_IDLE && bl_busy && bl_led == 1'b0 && !bl_start) begin
            led_next = 1'b0;
        end
        // analog path select
        path_next.mic_rec    = cmd_next.record && (passthru_select_n || mix_en);
        path_next.aux_rec    = cmd_next.record && !passthru_select_n;
        path_next.aux_thru   = !passthru_select_n && (!cmd_next.record || monitor_en) && !cmd_next.play;
        path_next.mic_thru   = (mix_en && !passthru_select_n && (!cmd_next.record || monitor_en) && !cmd_next.play)
                             || (passthru_select_n && cmd_next.record && monitor_en);
        path_next.aux_to_out = cmd_next.play && !passthru_select_n;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            db_reg        <= 4'h0;
            db_prev_reg   <= 4'h0;
            dbc_reg       <= 32'h0;
            st_reg        <= ST_INIT;
            rec_ptr_reg   <= pbm_pkg::FIRST_MSG_ROW;
            play_ptr_reg  <= pbm_pkg::FIRST_MSG_ROW;
            start_reg     <= pbm_pkg::FIRST_MSG_ROW;
            has_msgs_reg  <= 1'b0;
            corrupt_reg   <= 1'b0;
            edit_reg      <= 1'b0;
            cue_sel_reg   <= 2'd0;
            hold_reg      <= 32'h0;
            hold_done_reg <= 1'b0;
            led           <= 1'b0;
            array_cmd     <= '0;
            analog_path   <= '0;
            powered_down  <= 1'b1;
            cue_edit_mode <= 1'b0;
        end else begin
            db_reg        <= db_next;
            db_prev_reg   <= db_reg;
            dbc_reg       <= dbc_next;
            st_reg        <= st_next;
            rec_ptr_reg   <= rec_ptr_next;
            play_ptr_reg  <= play_ptr_next;
            start_reg     <= start_next;
            has_msgs_reg  <= has_msgs_next;
            corrupt_reg   <= corrupt_next;
            edit_reg      <= edit_next;
            cue_sel_reg   <= cue_sel_next;
            hold_reg      <= hold_next;
            hold_done_reg <= hold_done_next;
            led           <= led_next;
            array_cmd     <= cmd_next;
            analog_path   <= path_next;
            powered_down  <= (st_next == ST_IDLE) && !bl_busy && !bl_start;
            cue_edit_mode <= edit_next;
        end
    end

    // checks
    property p_cap_ignored_busy;
        @(posedge clk) disable iff (sys_rst)
        (st_reg == ST_IDLE && bl_busy && cap_rise) |=> (st_reg == ST_IDLE);
    endproperty
    a_cap_ignored_busy: assert property (p_cap_ignored_busy) else $error("capture taken while busy");

    property p_ptr_in_area;
        @(posedge clk) disable iff (sys_rst)
        (st_reg != ST_INIT) |-> (rec_ptr_reg >= pbm_pkg::FIRST_MSG_ROW && play_ptr_reg >= pbm_pkg::FIRST_MSG_ROW);
    endproperty
    a_ptr_in_area: assert property (p_ptr_in_area) else $error("pointer in cue area");

    property p_rec_led_on;
        @(posedge clk) disable iff (sys_rst)
        (st_reg == ST_REC && st_next == ST_REC) |=> led;
    endproperty
    a_rec_led_on: assert property (p_rec_led_on) else $error("led off during record");

    property p_rec_end_ptrs;
        @(posedge clk) disable iff (sys_rst)
        (st_reg == ST_REC && st_next == ST_CUE_OUT && !edit_reg) |=> (play_ptr_reg == $past(start_reg));
    endproperty
    a_rec_end_ptrs: assert property (p_rec_end_ptrs) else $error("playback pointer not at new message");

    property p_play_ptr_stable;
        @(posedge clk) disable iff (sys_rst)
        (st_reg != ST_INIT && !(st_reg == ST_REC)) |=> $stable(play_ptr_reg);
    endproperty
    a_play_ptr_stable: assert property (p_play_ptr_stable) else $error("playback pointer moved");

    property p_rec_stops;
        @(posedge clk) disable iff (sys_rst)
        (st_reg == ST_REC && array_full) |=> !array_cmd.record;
    endproperty
    a_rec_stops: assert property (p_rec_stops) else $error("record beyond full");

    property p_done_idle;
        @(posedge clk) disable iff (sys_rst)
        (st_reg == ST_CUE_OUT && !bl_busy) |=> (st_reg == ST_IDLE);
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("no return to idle");

    property p_edit_cue_row;
        @(posedge clk) disable iff (sys_rst)
        (st_reg == ST_EDITOP) |-> (array_cmd.row < W'(pbm_pkg::RESERVED_ROWS));
    endproperty
    a_edit_cue_row: assert property (p_edit_cue_row) else $error("edit outside cue rows");
endmodule

//--- pkg/pbm_pkg.sv
// shared constants and types for the push-button message manager
package pbm_pkg;
    localparam int ROW_W          = 11;
    localparam int ROW_COUNT      = 2048;
    localparam int CUE_ROWS       = 4;
    localparam int CUE_COUNT      = 4;
    localparam int RESERVED_ROWS  = 16;
    localparam logic [ROW_W-1:0] FIRST_MSG_ROW = 11'h010;
    localparam logic [ROW_W-1:0] LAST_ROW      = 11'h7ff;
    localparam int CLK_HZ         = 10_000_000;
    localparam int HOLD_MS        = 3000;
    localparam int HOLD_CYCLES    = HOLD_MS / 1000 * CLK_HZ;
    localparam int DEFAULT_BLINK_MS = 200;
    localparam int DEFAULT_BLINK_CYCLES = DEFAULT_BLINK_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_US    = 10_000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int CORRUPT_BLINKS = 7;
    // cue length in ms per sample-rate code 0..4 (12, 8, 6.4, 5.3, 4 kHz)
    localparam int CUE_MS_12K  = 330;
    localparam int CUE_MS_8K   = 500;
    localparam int CUE_MS_6K4  = 625;
    localparam int CUE_MS_5K3  = 750;
    localparam int CUE_MS_4K   = 1000;
    localparam int CUE_STEP_MS = 1;

    typedef struct packed {
        logic capture_key_n;
        logic advance_key_n;
        logic listen_key_n;
        logic clear_key_n;
    } keys_s;

    typedef struct packed {
        logic record;
        logic play;
        logic erase;
        logic [ROW_W-1:0] row;
    } array_cmd_s;

    typedef struct packed {
        logic mic_rec;
        logic aux_rec;
        logic aux_thru;
        logic mic_thru;
        logic aux_to_out;
    } analog_path_s;
endpackage

//--- src/blink_unit.sv
// led blink sequencer: n blinks of a given half period
`timescale 1ns/1ps
module blink_unit #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // request
    input  wire logic             start,
    input  wire logic [3:0]       count,
    input  wire logic [CNT_W-1:0] period,
    // status
    output logic                  led,
    output logic                  busy
);
    logic [3:0]       left_reg, left_next;
    logic [CNT_W-1:0] tick_reg, tick_next, per_reg, per_next;
    logic             led_next, busy_next;

    always_comb begin
        left_next = left_reg;
        tick_next = tick_reg;
        per_next  = per_reg;
        led_next  = led;
        busy_next = busy;
        if (start && !busy) begin
            left_next = count;
            per_next  = period;
            tick_next = period;
            led_next  = 1'b1;
            busy_next = (count != 4'h0);
        end else if (busy) begin
            if (tick_reg > 1) begin
                tick_next = tick_reg - 1'b1;
            end else begin
                tick_next = per_reg;
                if (led) begin
                    led_next  = 1'b0;
                    left_next = left_reg - 4'h1;
                end else if (left_reg != 4'h0) begin
                    led_next = 1'b1;
                end else begin
                    busy_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            left_reg <= 4'h0;
            tick_reg <= '0;
            per_reg  <= '0;
            led      <= 1'b0;
            busy     <= 1'b0;
        end else begin
            left_reg <= left_next;
            tick_reg <= tick_next;
            per_reg  <= per_next;
            led      <= led_next;
            busy     <= busy_next;
        end
    end
endmodule

//--- sim/button_panel.sv
// model of the user side: push buttons and an eye on the led
`timescale 1ns/1ps
module button_panel (
    // clock and indicator
    input  wire logic clk,
    input  wire logic led,
    // buttons
    output pbm_pkg::keys_s keys
);
    initial keys = 4'hf;
    // key index: 3 capture, 2 advance, 1 listen, 0 clear
    task automatic set_key(input int k, input logic lvl);
        @(negedge clk);
        keys[k] = lvl;
    endtask
    // user waits for the led to stay dark before a new command
    task automatic wait_quiet();
        int q;
        q = 0;
        while (q < 12) begin
            @(negedge clk);
            q = led ? 0 : q + 1;
        end
    endtask
endmodule

//--- sim/pushbutton_message_manager_test.sv
// self-checking bench for the push-button message manager
`timescale 1ns/1ps
module pushbutton_message_manager_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    pbm_pkg::keys_s keys;
    logic [2:0] rate_sel = 3'h0;
    logic has_msgs = 1'b0;
    logic corrupt = 1'b0;
    logic [pbm_pkg::ROW_W-1:0] last_start = 11'h000;
    logic [pbm_pkg::ROW_W-1:0] next_free = 11'h000;
    logic [3:0] cue_prog = 4'h0;
    logic full = 1'b0;
    logic row_done = 1'b0;
    logic play_done = 1'b0;
    logic passthru_n = 1'b1;
    logic mon = 1'b0;
    logic mix = 1'b0;
    pbm_pkg::array_cmd_s cmd;
    pbm_pkg::analog_path_s path;
    logic pd;
    logic edit;
    logic led;
    int err_count = 0;
    int n_checks = 0;
    always #50 clk = ~clk;
    button_panel panel (.clk(clk), .led(led), .keys(keys));
    pushbutton_message_manager #(.HOLD_CYCLES(50), .BLINK_CYCLES(4), .DEBOUNCE_CYCLES(2)) uut (
        .clk(clk), .sys_rst(sys_rst), .keys(keys), .passthru_select_n(passthru_n), .monitor_en(mon),
        .mix_en(mix), .rate_sel(rate_sel), .restore_valid(1'b1), .restore_has_msgs(has_msgs),
        .restore_corrupt(corrupt), .restore_last_start(last_start), .restore_next_free(next_free),
        .cue_programmed(cue_prog), .array_full(full), .array_row_done(row_done),
        .cue_play_done(play_done), .array_cmd(cmd), .analog_path(path), .powered_down(pd),
        .cue_edit_mode(edit), .led(led));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic do_reset(input logic h, input logic c, input logic [10:0] ls, input logic [10:0] nf);
        @(negedge clk);
        sys_rst = 1'b1;
        has_msgs = h;
        corrupt = c;
        last_start = ls;
        next_free = nf;
        repeat (20) @(negedge clk);
        chk("reset powered_down", 16'h1, {15'h0, pd});
        chk("reset led", 16'h0, {15'h0, led});
        chk("reset cmd", 16'h0, {2'h0, cmd});
        sys_rst = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    // capture, write a given number of rows, release
    task automatic rec_msg(input logic [10:0] exp_row, input int rows, input logic [4:0] exp_path);
        int n;
        panel.set_key(3, 1'b0);
        n = 0;
        while (cmd.record !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("record start", 16'h1, {15'h0, cmd.record});
        chk("record row", {5'h0, exp_row}, {5'h0, cmd.row});
        chk("led on while recording", 16'h1, {15'h0, led});
        chk("not powered down", 16'h0, {15'h0, pd});
        chk("record path", {11'h0, exp_path}, {11'h0, path});
        repeat (rows) begin
            row_done = 1'b1;
            @(negedge clk);
            row_done = 1'b0;
            @(negedge clk);
        end
        chk("record held", 16'h1, {15'h0, cmd.record});
        panel.set_key(3, 1'b1);
        n = 0;
        while (pd !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("record stopped", 16'h0, {15'h0, cmd.record});
        chk("led off after record", 16'h0, {15'h0, led});
        chk("back to power-down", 16'h1, {15'h0, pd});
        panel.wait_quiet();
    endtask
    // count led flashes over a window
    task automatic count_blinks(input int cycles, output int b);
        logic last;
        b = 0;
        last = led;
        repeat (cycles) begin
            @(negedge clk);
            if (led && !last)
                b++;
            last = led;
        end
    endtask
    task automatic test_record_pointers();
        do_reset(1'b0, 1'b0, 11'h000, 11'h000);
        rec_msg(pbm_pkg::FIRST_MSG_ROW, 2, 5'h10);
        rec_msg(pbm_pkg::FIRST_MSG_ROW + 11'h003, 1, 5'h10);
        panel.set_key(3, 1'b0);
        repeat (6) @(negedge clk);
        chk("full record row", 16'h15, {5'h0, cmd.row});
        full = 1'b1;
        @(negedge clk);
        full = 1'b0;
        chk("stop on full", 16'h0, {15'h0, cmd.record});
        chk("led off on full", 16'h0, {15'h0, led});
        panel.set_key(3, 1'b1);
        panel.wait_quiet();
        $display("test record_pointers done");
    endtask
    task automatic test_restore_wrap();
        passthru_n = 1'b0;
        mon = 1'b1;
        do_reset(1'b1, 1'b0, 11'h7f0, pbm_pkg::LAST_ROW);
        rec_msg(pbm_pkg::LAST_ROW, 1, 5'h0c);
        mix = 1'b1;
        rec_msg(pbm_pkg::FIRST_MSG_ROW + 11'h001, 1, 5'h1e);
        chk("idle path", 16'h06, {11'h0, path});
        passthru_n = 1'b1;
        mon = 1'b0;
        mix = 1'b0;
        $display("test restore_wrap done");
    endtask
    // listen or clear on the selected cue, ended by the array
    task automatic edit_op(input int k, input logic [1:0] exp_op);
        panel.set_key(k, 1'b0);
        repeat (6) @(negedge clk);
        chk("edit op", {14'h0, exp_op}, {14'h0, cmd.play, cmd.erase});
        chk("edit op row", 16'h4, {5'h0, cmd.row});
        play_done = 1'b1;
        @(negedge clk);
        play_done = 1'b0;
        panel.set_key(k, 1'b1);
        chk("edit op done", 16'h0, {14'h0, cmd.play, cmd.erase});
        panel.wait_quiet();
    endtask
    task automatic test_cue_edit();
        int b;
        do_reset(1'b0, 1'b0, 11'h000, 11'h000);
        panel.set_key(2, 1'b0);
        count_blinks(100, b);
        panel.set_key(3, 1'b0);
        count_blinks(60, b);
        chk("edit enter blinks", 16'd2, b[15:0]);
        chk("edit mode on", 16'h1, {15'h0, edit});
        panel.set_key(3, 1'b1);
        panel.set_key(2, 1'b1);
        panel.wait_quiet();
        panel.set_key(2, 1'b0);
        count_blinks(60, b);
        panel.set_key(2, 1'b1);
        chk("cue two blinks", 16'd2, b[15:0]);
        panel.wait_quiet();
        edit_op(0, 2'b01);
        rec_msg(11'h004, 0, 5'h10);
        edit_op(1, 2'b10);
        panel.set_key(2, 1'b0);
        count_blinks(100, b);
        chk("cue three blinks", 16'd3, b[15:0]);
        panel.set_key(3, 1'b0);
        count_blinks(60, b);
        chk("edit exit blinks", 16'd2, b[15:0]);
        chk("edit mode off", 16'h0, {15'h0, edit});
        panel.set_key(3, 1'b1);
        panel.set_key(2, 1'b1);
        panel.wait_quiet();
        $display("test cue_edit done");
    endtask
    task automatic test_corrupt();
        int b;
        do_reset(1'b1, 1'b1, 11'h020, 11'h030);
        panel.set_key(3, 1'b0);
        count_blinks(300, b);
        panel.set_key(3, 1'b1);
        chk("corrupt blinks", 16'd7, b[15:0]);
        chk("no record when corrupt", 16'h0, {15'h0, cmd.record});
        panel.wait_quiet();
        chk("idle after failure", 16'h1, {15'h0, pd});
        $display("test corrupt done");
    endtask
    task automatic test_long_advance();
        int b;
        int b2;
        do_reset(1'b0, 1'b0, 11'h000, 11'h000);
        panel.set_key(2, 1'b0);
        count_blinks(150, b);
        panel.set_key(2, 1'b1);
        count_blinks(100, b2);
        chk("advance blinks empty", 16'd2, b[15:0] + b2[15:0]);
        chk("edit mode stays off", 16'h0, {15'h0, edit});
        chk("idle after advance", 16'h1, {15'h0, pd});
        $display("test long_advance done");
    endtask
    initial begin
        test_record_pointers();
        test_restore_wrap();
        test_corrupt();
        test_long_advance();
        test_cue_edit();
        end_of_test();
    end
    initial begin
        #(100 * 20000);
        err_count++;
        end_of_test();
    end
endmodule
